// ===== hw/trap_defs.svh
`ifndef TRAP_DEFS_SVH
`define TRAP_DEFS_SVH
`define NUM_SRC 56
`define TRAP_RESET 7'h00
`define TRAP_NMI 7'h02
`define TRAP_STACK_OVERFLOW_FLAG 7'h04
`define TRAP_STACK_UNDERFLOW_FLAG 7'h06
`define TRAP_CLASS_B 7'h0a
`define TRAP_CC18 7'h32
`define TRAP_CC29 7'h44
`define TF_NMI 15
`define TF_STACK_OVERFLOW_FLAG 14
`define TF_STACK_UNDERFLOW_FLAG 13
`define TF_UNDEFINED_OPCODE_FLAG 7
`define TF_PROTECTED_INSTRUCTION_FAULT_FLAG 3
`define TF_ILLEGAL_WORD_OPERAND_FLAG 2
`define TF_ILLEGAL_INSTRUCTION_ACCESS_FLAG 1
`define TF_ILLEGAL_EXTERNAL_BUS_FLAG 0
`define PRIO_RESET 2'h3
`define PRIO_CLASS_A 2'h2
`define PRIO_CLASS_B 2'h1
`define PRIO_NONE 2'h0
`endif

// ===== hw/trap_pkg.sv
package trap_pkg;
    typedef logic [6:0] trap_num_t;
    typedef logic [8:0] vec_addr_t;
    typedef logic [3:0] int_level_t;
    typedef logic [1:0] trap_class_t;
    typedef enum logic [1:0] {
        SVC_IDLE,
        SVC_INT,
        SVC_TRAP
    } svc_state_t;
endpackage

// ===== hw/source_trap_table.sv
`timescale 1ns/1ps
`include "trap_defs.svh"
// maps a peripheral source index to its trap number
module source_trap_table (
    input wire logic [5:0] src_i,
    output trap_pkg::trap_num_t trap_o
);
    import trap_pkg::*;
    // capture/compare channels 0..15, then 16..28 continuing at 30h
    always_comb begin
        if (src_i < 6'd16) begin
            trap_o = 7'h10 + {1'b0, src_i};
        end else if (src_i < 6'd29) begin
            trap_o = 7'h30 + {1'b0, src_i} - 7'h10;
        end else if (src_i < 6'd32) begin
            trap_o = `TRAP_CC29 + {1'b0, src_i} - 7'h1d;
        end else if (src_i < 6'd48) begin
            // timers, converter and serial sources: 20h..2Fh
            trap_o = 7'h20 + {1'b0, src_i} - 7'h20;
        end else if (src_i < 6'd50) begin
            trap_o = 7'h3d + {1'b0, src_i} - 7'h30;
        end else if (src_i == 6'd50) begin
            trap_o = 7'h47;
        end else if (src_i < 6'd56) begin
            trap_o = 7'h3f + {1'b0, src_i} - 7'h33;
        end else begin
            trap_o = 7'h00;
        end
    end
endmodule

// ===== hw/trap_vector_ctrl.sv
`timescale 1ns/1ps
`include "trap_defs.svh"
module trap_vector_ctrl (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [`NUM_SRC-1:0] req_set_i,
    input wire logic [`NUM_SRC-1:0] enable_i,
    input wire logic [`NUM_SRC*4-1:0] level_i,
    input wire logic soft_reset_i,
    input wire logic watchdog_ovf_i,
    input wire logic nmi_i,
    input wire logic stack_overflow_i,
    input wire logic stack_underflow_i,
    input wire logic undef_opcode_i,
    input wire logic prot_fault_i,
    input wire logic illegal_operand_i,
    input wire logic illegal_instr_i,
    input wire logic illegal_bus_i,
    input wire logic sw_trap_i,
    input wire trap_pkg::trap_num_t sw_trap_num_i,
    input wire logic svc_done_i,
    input wire logic [15:0] flag_clr_i,
    output logic take_o,
    output trap_pkg::trap_num_t trap_num_o,
    output trap_pkg::vec_addr_t vector_o,
    output trap_pkg::int_level_t cpu_level_o,
    output logic in_trap_o,
    output logic [`NUM_SRC-1:0] req_flag_o,
    output logic [15:0] trap_flag_register_o
);
    import trap_pkg::*;

    function automatic vec_addr_t vec_of(input trap_num_t t);
        vec_of = {t, 2'b00};
    endfunction

    svc_state_t state_q;
    logic [`NUM_SRC-1:0] req_q;
    logic [15:0] tfr_q;
    trap_class_t trap_prio_q;
    int_level_t cpu_level_q;
    logic take_q;
    trap_num_t trap_num_q;
    vec_addr_t vector_q;
    logic [5:0] win_idx;
    int_level_t win_lvl;
    logic win_valid;
    trap_num_t win_trap;
    trap_class_t hw_class;
    trap_num_t hw_trap;
    logic reset_evt;
    logic [15:0] tf_set;
    logic [5:0] ack_idx_q;
    logic ack_int_q;
    logic in_trap_q;

    assign reset_evt = soft_reset_i | watchdog_ovf_i;

    // set vector for individual trap flags, one bit per flag, several may be set at once
    always_comb begin
        tf_set = 16'h0000;
        tf_set[`TF_NMI] = nmi_i;
        tf_set[`TF_STACK_OVERFLOW_FLAG] = stack_overflow_i;
        tf_set[`TF_STACK_UNDERFLOW_FLAG] = stack_underflow_i;
        tf_set[`TF_UNDEFINED_OPCODE_FLAG] = undef_opcode_i;
        tf_set[`TF_PROTECTED_INSTRUCTION_FAULT_FLAG] = prot_fault_i;
        tf_set[`TF_ILLEGAL_WORD_OPERAND_FLAG] = illegal_operand_i;
        tf_set[`TF_ILLEGAL_INSTRUCTION_ACCESS_FLAG] = illegal_instr_i;
        tf_set[`TF_ILLEGAL_EXTERNAL_BUS_FLAG] = illegal_bus_i;
    end

    // highest pending hardware trap class, fixed order within class A
    always_comb begin
        hw_class = `PRIO_NONE;
        hw_trap = `TRAP_RESET;
        if (reset_evt) begin
            hw_class = `PRIO_RESET;
            hw_trap = `TRAP_RESET;
        end else if (nmi_i) begin
            hw_class = `PRIO_CLASS_A;
            hw_trap = `TRAP_NMI;
        end else if (stack_overflow_i) begin
            hw_class = `PRIO_CLASS_A;
            hw_trap = `TRAP_STACK_OVERFLOW_FLAG;
        end else if (stack_underflow_i) begin
            hw_class = `PRIO_CLASS_A;
            hw_trap = `TRAP_STACK_UNDERFLOW_FLAG;
        end else if (|tf_set[`TF_UNDEFINED_OPCODE_FLAG:0]) begin
            hw_class = `PRIO_CLASS_B;
            hw_trap = `TRAP_CLASS_B;
        end
    end

    // best enabled pending source; ties go to the lower index
    always_comb begin
        win_valid = 1'b0;
        win_idx = 6'd0;
        win_lvl = 4'h0;
        for (int i = 0; i < `NUM_SRC; i++) begin
            if (req_q[i] && enable_i[i] &&
                (!win_valid || level_i[i*4 +: 4] > win_lvl)) begin
                win_valid = 1'b1;
                win_idx = 6'(i);
                win_lvl = level_i[i*4 +: 4];
            end
        end
    end

    source_trap_table u_table (
        .src_i(win_idx),
        .trap_o(win_trap)
    );

    // request flags: hardware set wins over the acknowledge clear
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            req_q <= '0;
        end else begin
            for (int i = 0; i < `NUM_SRC; i++) begin
                if (req_set_i[i]) begin
                    req_q[i] <= 1'b1;
                end else if (ack_int_q && ack_idx_q == 6'(i)) begin
                    // only an interrupt take acknowledges, never a sw trap
                    req_q[i] <= 1'b0;
                end
            end
        end
    end

    // trap flags: set wins over software clear
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tfr_q <= 16'h0000;
        end else begin
            tfr_q <= (tfr_q & ~flag_clr_i) | tf_set;
        end
    end

    // service sequencer and vector output
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q <= SVC_IDLE;
            trap_prio_q <= `PRIO_NONE;
            cpu_level_q <= 4'h0;
            take_q <= 1'b0;
            trap_num_q <= `TRAP_RESET;
            vector_q <= 9'h000;
            ack_idx_q <= 6'd0;
            ack_int_q <= 1'b0;
            in_trap_q <= 1'b0;
        end else begin
            take_q <= 1'b0;
            ack_int_q <= 1'b0;
            if (hw_class != `PRIO_NONE && hw_class > trap_prio_q) begin
                state_q <= SVC_TRAP;
                in_trap_q <= 1'b1;
                trap_prio_q <= hw_class;
                take_q <= 1'b1;
                trap_num_q <= hw_trap;
                vector_q <= vec_of(hw_trap);
            end else if (state_q != SVC_TRAP && win_valid &&
                         (state_q == SVC_IDLE || win_lvl > cpu_level_q))
            begin
                state_q <= SVC_INT;
                cpu_level_q <= win_lvl;
                take_q <= 1'b1;
                trap_num_q <= win_trap;
                vector_q <= vec_of(win_trap);
                ack_idx_q <= win_idx;
                ack_int_q <= 1'b1;
                in_trap_q <= 1'b0;
            end else if (sw_trap_i && state_q != SVC_TRAP) begin
                take_q <= 1'b1; // level unchanged
                trap_num_q <= sw_trap_num_i;
                vector_q <= vec_of(sw_trap_num_i);
            end else if (svc_done_i) begin
                // nesting depth is not tracked; done returns to idle
                state_q <= SVC_IDLE;
                in_trap_q <= 1'b0;
                trap_prio_q <= `PRIO_NONE;
                cpu_level_q <= 4'h0;
            end
        end
    end

    assign take_o = take_q;
    assign trap_num_o = trap_num_q;
    assign vector_o = vector_q;
    assign cpu_level_o = cpu_level_q;
    assign in_trap_o = in_trap_q;
    assign req_flag_o = req_q;
    assign trap_flag_register_o = tfr_q;

    AST_VEC_IS_4X: assert property (@(posedge sys_clk_i) disable iff
        (!rst_n_i) take_o |-> vector_o == {trap_num_o, 2'b00})
        else $error("vector not four times trap");
    AST_NMI_TAKEN: assert property (@(posedge sys_clk_i) disable iff
        (!rst_n_i) nmi_i && !reset_evt && trap_prio_q < `PRIO_CLASS_A
        |=> take_o && trap_num_o == 7'h02)
        else $error("nmi not vectored");
    AST_FLAG_SET: assert property (@(posedge sys_clk_i) disable iff
        (!rst_n_i) illegal_bus_i |=> tfr_q[`TF_ILLEGAL_EXTERNAL_BUS_FLAG])
        else $error("trap flag not set");
    AST_RESET_VEC: assert property (@(posedge sys_clk_i) disable iff
        (!rst_n_i) reset_evt && trap_prio_q != `PRIO_RESET
        |=> vector_o == 9'h000 && take_o)
        else $error("reset trap wrong");
    AST_CLASS_B: assert property (@(posedge sys_clk_i) disable iff
        (!rst_n_i) undef_opcode_i && hw_class == `PRIO_CLASS_B &&
        trap_prio_q == `PRIO_NONE |=> trap_num_o == 7'h0a)
        else $error("class b trap wrong");
    AST_NO_INT_IN_TRAP: assert property (@(posedge sys_clk_i) disable iff
        (!rst_n_i) in_trap_o && hw_class == `PRIO_NONE
        |=> !(take_o && !in_trap_o))
        else $error("interrupt preempted trap");
    AST_STRICT_LEVEL: assert property (@(posedge sys_clk_i) disable iff
        (!rst_n_i) ack_int_q && $past(state_q) == SVC_INT
        |-> cpu_level_q > $past(cpu_level_q))
        else $error("preempt at equal level");
    AST_SW_LEVEL: assert property (@(posedge sys_clk_i) disable iff
        (!rst_n_i) sw_trap_i && hw_class == `PRIO_NONE && !win_valid &&
        state_q != SVC_TRAP |=> $stable(cpu_level_o) && take_o)
        else $error("software trap wrong");
    CV_NMI: cover property (@(posedge sys_clk_i) take_o && trap_num_o == 7'h02);
    CV_INT: cover property (@(posedge sys_clk_i) take_o && state_q == SVC_INT);
    CV_SW: cover property (@(posedge sys_clk_i) sw_trap_i ##1 take_o);
endmodule

// ===== test/cpu_model.sv
`timescale 1ns/1ps
// core stand-in: returns from each service delay_i+2 cycles after take_i rises
module cpu_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic take_i,
    input wire logic [3:0] delay_i,
    output logic done_o
);
    logic [4:0] cnt_q;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 5'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_q == 5'h01);
            if (take_i) begin
                cnt_q <= {1'b0, delay_i} + 5'h01;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "trap_defs.svh"
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin \
    mismatches++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
    import trap_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [`NUM_SRC-1:0] req_set_i = '0;
    logic [`NUM_SRC-1:0] enable_i = '0;
    logic [`NUM_SRC-1:0] one = 1;
    logic [`NUM_SRC*4-1:0] level_i = '0;
    logic [9:0] hw = '0;
    logic sw_trap_i = 1'b0;
    trap_num_t sw_trap_num_i = '0;
    logic svc_done_i, take_o, in_trap_o;
    logic [15:0] flag_clr_i = '0;
    logic [3:0] delay = 4'h2;
    trap_num_t trap_num_o, t;
    vec_addr_t vector_o;
    int_level_t cpu_level_o, lv;
    logic [`NUM_SRC-1:0] req_flag_o;
    logic [15:0] trap_flag_register_o;
    int mismatches = 0, tests_run = 0, seed = 32'h85dbfe75, c;
    int fbit[10] = '{-1, -1, `TF_NMI, `TF_STACK_OVERFLOW_FLAG, `TF_STACK_UNDERFLOW_FLAG, `TF_UNDEFINED_OPCODE_FLAG,
        `TF_PROTECTED_INSTRUCTION_FAULT_FLAG, `TF_ILLEGAL_WORD_OPERAND_FLAG, `TF_ILLEGAL_INSTRUCTION_ACCESS_FLAG, `TF_ILLEGAL_EXTERNAL_BUS_FLAG};
    trap_vector_ctrl i_trap_vector_ctrl (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .req_set_i(req_set_i), .enable_i(enable_i),
        .level_i(level_i), .soft_reset_i(hw[0]), .watchdog_ovf_i(hw[1]),
        .nmi_i(hw[2]), .stack_overflow_i(hw[3]), .stack_underflow_i(hw[4]),
        .undef_opcode_i(hw[5]), .prot_fault_i(hw[6]),
        .illegal_operand_i(hw[7]), .illegal_instr_i(hw[8]),
        .illegal_bus_i(hw[9]), .sw_trap_i(sw_trap_i),
        .sw_trap_num_i(sw_trap_num_i), .svc_done_i(svc_done_i),
        .flag_clr_i(flag_clr_i), .take_o(take_o), .trap_num_o(trap_num_o),
        .vector_o(vector_o), .cpu_level_o(cpu_level_o),
        .in_trap_o(in_trap_o), .req_flag_o(req_flag_o),
        .trap_flag_register_o(trap_flag_register_o));
    cpu_model i_cpu_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .take_i(take_o), .delay_i(delay), .done_o(svc_done_i));
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    function automatic trap_num_t hw_trap(int i);
        return i < 2 ? `TRAP_RESET : i < 5 ? 7'(2 * (i - 1)) : `TRAP_CLASS_B;
    endfunction
    function automatic trap_num_t cc_trap(int k);
        if (k < 16) return 7'h10 + 7'(k);
        if (k < 29) return 7'h30 + 7'(k - 16);
        if (k < 32) return 7'h44 + 7'(k - 29);
        if (k < 48) return 7'h20 + 7'(k - 32);
        if (k < 50) return 7'h3d + 7'(k - 48);
        if (k == 50) return 7'h47;
        return 7'h3f + 7'(k - 51);
    endfunction
    task automatic expect_take(trap_num_t et);
        int i;
        #1;
        for (i = 0; i < 8 && take_o !== 1'b1; i++) @(posedge sys_clk_i) #1;
        `CHK("take_o", 1'b1, take_o)
        `CHK("trap_num_o", et, trap_num_o)
        `CHK("vector_o", {et, 2'b00}, vector_o)
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 40 && svc_done_i !== 1'b1; i++) begin
            @(posedge sys_clk_i) #1;
        end
        `CHK("svc_done_i", 1'b1, svc_done_i)
        @(posedge sys_clk_i);
    endtask
    task automatic no_take(int n);
        repeat (n) begin
            @(posedge sys_clk_i) #1;
            `CHK("no take", 1'b0, take_o)
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i) #1;
        `CHK("flags", 16'h0000, trap_flag_register_o)
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk_i) flag_clr_i <= 16'hffff;
            @(posedge sys_clk_i) begin
                flag_clr_i <= 16'h0000;
                hw[i] <= 1'b1;
            end
            @(posedge sys_clk_i) hw <= '0;
            expect_take(hw_trap(i));
            `CHK("flags", fbit[i] < 0 ? 16'h0 : 16'h1 << fbit[i],
                trap_flag_register_o)
            wait_done();
        end
        $display("hardware trap test done");
        // both arrive together: class A is served first, class B waits
        // while its cause persists, since no trap is queued internally
        @(posedge sys_clk_i) hw <= 10'h024;
        @(posedge sys_clk_i) hw <= 10'h020;
        expect_take(`TRAP_NMI);
        wait_done();
        expect_take(`TRAP_CLASS_B);
        @(posedge sys_clk_i) hw <= '0;
        wait_done();
        $display("trap priority test done");
        for (int n = 0; n < 12; n++) begin
            c = n == 0 ? 28 : n == 1 ? 31 : $unsigned($random(seed)) % 56;
            lv = 4'h1 + 4'($unsigned($random(seed)) % 15);
            @(posedge sys_clk_i) begin
                enable_i <= one << c;
                level_i[c*4 +: 4] <= lv;
                req_set_i <= one << c;
            end
            @(posedge sys_clk_i) req_set_i <= '0;
            expect_take(cc_trap(c));
            `CHK("cpu_level_o", lv, cpu_level_o)
            wait_done();
        end
        $display("interrupt test done");
        @(posedge sys_clk_i) begin
            enable_i <= '0;
            level_i[23:20] <= 4'h3;
            req_set_i <= one << 5;
        end
        @(posedge sys_clk_i) req_set_i <= '0;
        no_take(6);
        `CHK("req_flag_o", 1'b1, req_flag_o[5])
        @(posedge sys_clk_i) enable_i <= one << 5;
        expect_take(7'h15);
        wait_done();
        $display("mask test done");
        // slow core: a request during a trap must wait for the return
        delay <= 4'ha;
        @(posedge sys_clk_i) hw[2] <= 1'b1;
        @(posedge sys_clk_i) begin
            hw <= '0;
            enable_i <= one << 3;
            level_i[15:12] <= 4'hf;
            req_set_i <= one << 3;
        end
        expect_take(`TRAP_NMI);
        `CHK("in_trap_o", 1'b1, in_trap_o)
        @(posedge sys_clk_i) req_set_i <= '0;
        no_take(4);
        wait_done();
        expect_take(7'h13);
        `CHK("in_trap_o", 1'b0, in_trap_o)
        wait_done();
        $display("trap blocking test done");
        // a higher level request preempts a running interrupt service
        @(posedge sys_clk_i) begin
            enable_i <= (one << 3) | (one << 4);
            level_i[15:12] <= 4'h2;
            level_i[19:16] <= 4'h5;
            req_set_i <= one << 3;
        end
        @(posedge sys_clk_i) req_set_i <= '0;
        expect_take(7'h13);
        @(posedge sys_clk_i) req_set_i <= one << 4;
        @(posedge sys_clk_i) req_set_i <= '0;
        expect_take(7'h14);
        `CHK("cpu_level_o", 4'h5, cpu_level_o)
        wait_done();
        $display("preemption test done");
        delay <= 4'h0;
        for (int n = 0; n < 8; n++) begin
            t = n == 0 ? 7'h7f : n == 1 ? 7'h00 : 7'($random(seed));
            @(posedge sys_clk_i) begin
                sw_trap_i <= 1'b1;
                sw_trap_num_i <= t;
            end
            @(posedge sys_clk_i) sw_trap_i <= 1'b0;
            expect_take(t);
            `CHK("cpu_level_o", 4'h0, cpu_level_o)
            wait_done();
        end
        $display("software trap test done");
        end_sim();
    end
endmodule
